// File: design/wd_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module wd_tick_div
  import wd_pkg::*;
#(
  parameter int unsigned CYCLES = WD_TICK_CYCLES
)
(
  input wire logic clk,
  input wire logic nrst,
  wd_tick_if.src tk
);

  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] div_q;
  logic tick_q;

  // Held while frozen so a resumed interval keeps its elapsed part
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_q <= '0;
    end
    else if (tk.run)
    begin
      if (div_q == LAST)
        div_q <= '0;
      else
        div_q <= div_q + W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      tick_q <= 1'b0;
    else
      tick_q <= tk.run && (div_q == LAST);
  end

  assign tk.tick = tick_q;

endmodule : wd_tick_div
`default_nettype wire

// File: design/wd_top.sv
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module wd_top
  import wd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = WD_TICK_CYCLES
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WD_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [WD_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [WD_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic debug_core_halted,
  output logic nmi_req,
  output logic timeout_system_reset
);

  wd_tick_if tk ();

  wd_bus_e bus_q;
  logic [WD_DATA_W-1:0] rdata_q;
  logic [WD_CNT_W-1:0] cnt_q;
  logic [WD_CNT_W-1:0] cnt_d;
  logic sel_q;
  logic frz_q;
  logic nmi_q;
  logic rst_q;
  logic reject_q;

  logic req;
  logic wr_fire;
  logic wr_count;
  logic wr_ctrl;
  logic wr_frz_set;
  logic wr_frz_clr;
  logic wr_status;
  logic guard_ok;
  logic frozen;
  logic fire;
  logic step;
  logic [WD_DATA_W-1:0] rd_mux;

  wd_tick_div #(
    .CYCLES(TICK_CYCLES)
  ) u_div (
    .clk(clk),
    .nrst(nrst),
    .tk(tk.src)
  );

  // Bus slave: one wait state for every access
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && (bus_q != WD_BUS_ACK);
  assign wr_fire = avs_write && (bus_q == WD_BUS_ACK);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_q <= WD_BUS_IDLE;
    end
    else
    begin
      unique case (bus_q)
        WD_BUS_IDLE:
        begin
          if (req)
            bus_q <= WD_BUS_ACK;
        end
        WD_BUS_ACK:
        begin
          bus_q <= WD_BUS_IDLE;
        end
      endcase
    end
  end

  // Write decode; low address bits ignored for aligned words
  assign wr_count = wr_fire && (avs_address[WD_ADDR_W-1:2] == WD_OFS_COUNT[WD_ADDR_W-1:2])
                    && avs_byteenable[0] && avs_byteenable[1];
  assign wr_ctrl = wr_fire && (avs_address[WD_ADDR_W-1:2] == WD_OFS_CTRL[WD_ADDR_W-1:2])
                   && avs_byteenable[0];
  assign wr_frz_set = wr_fire && (avs_address[WD_ADDR_W-1:2] == WD_OFS_FRZ_SET[WD_ADDR_W-1:2])
                      && avs_byteenable[0];
  assign wr_frz_clr = wr_fire && (avs_address[WD_ADDR_W-1:2] == WD_OFS_FRZ_CLR[WD_ADDR_W-1:2])
                      && avs_byteenable[0];
  assign wr_status = wr_fire && (avs_address[WD_ADDR_W-1:2] == WD_OFS_STATUS[WD_ADDR_W-1:2])
                     && avs_byteenable[0];

  assign guard_ok = !avs_writedata[WD_GUARD_BIT];

  // software freeze only counts in mode 0
  assign frozen = debug_core_halted || (frz_q && !sel_q);
  assign tk.run = !frozen && !rst_q;

  // mode 1 fires at zero or below
  // mode 0 fires at -16 or below
  assign fire = sel_q ? wd_at_or_below(cnt_q, WD_COUNT_ZERO)
                      : wd_at_or_below(cnt_q, WD_COUNT_NEG_LIMIT);

  // Counting stops once a timeout is pending so the value cannot wrap positive
  assign step = tk.tick && !frozen && !fire && !rst_q;

  // wraps 000 to 1FF, setting the sign bit
  always_comb
  begin
    cnt_d = cnt_q;
    if (wr_count && guard_ok)
      cnt_d = avs_writedata[WD_CNT_W-1:0];
    else if (step)
      cnt_d = cnt_q - WD_COUNT_ONE;
  end

  // system reset from the tree reloads 255
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= WD_COUNT_RST;
    else
      cnt_q <= cnt_d;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sel_q <= 1'b0;
    else if (wr_ctrl && avs_writedata[WD_SEL_BIT])
      sel_q <= 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      frz_q <= 1'b0;
    else if (wr_frz_set && avs_writedata[WD_FRZ_BIT] && !sel_q)
      frz_q <= 1'b1;
    else if (wr_frz_clr && avs_writedata[WD_FRZ_BIT])
      frz_q <= 1'b0;
  end

  // NMI when count steps to zero in mode 0
  // Clear by a reload wins over the set
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      nmi_q <= 1'b0;
    else if (step && !sel_q && (cnt_q == WD_COUNT_ONE) && !(wr_count && guard_ok))
      nmi_q <= 1'b1;
    else if (wr_count && guard_ok)
      nmi_q <= 1'b0;
  end

  // handler reload clears fire before it latches
  // held until the system reset tree resets the block
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_q <= 1'b0;
    else if (fire && !(wr_count && guard_ok))
      rst_q <= 1'b1;
  end

  // Rejected counter writes are flagged; write one to clear, set wins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reject_q <= 1'b0;
    else if (wr_count && !guard_ok)
      reject_q <= 1'b1;
    else if (wr_status && avs_writedata[WD_ST_REJECT])
      reject_q <= 1'b0;
  end

  // Read mux; unmapped words read zero
  always_comb
  begin
    rd_mux = '0;
    unique case (avs_address[WD_ADDR_W-1:2])
      WD_OFS_COUNT[WD_ADDR_W-1:2]:
        rd_mux[WD_CNT_W-1:0] = cnt_q;
      WD_OFS_CTRL[WD_ADDR_W-1:2]:
        rd_mux[WD_SEL_BIT] = sel_q;
      WD_OFS_FRZ_SET[WD_ADDR_W-1:2]:
        rd_mux[WD_FRZ_BIT] = frz_q;
      WD_OFS_FRZ_CLR[WD_ADDR_W-1:2]:
        rd_mux[WD_FRZ_BIT] = frz_q;
      WD_OFS_STATUS[WD_ADDR_W-1:2]:
      begin
        rd_mux[WD_ST_FROZEN] = frozen;
        rd_mux[WD_ST_DBG] = debug_core_halted;
        rd_mux[WD_ST_SWFRZ] = frz_q;
        rd_mux[WD_ST_NMI] = nmi_q;
        rd_mux[WD_ST_NEG] = cnt_q[WD_SIGN_BIT];
        rd_mux[WD_ST_REJECT] = reject_q;
        rd_mux[WD_ST_FIRED] = rst_q;
      end
      default:
        rd_mux = '0;
    endcase
  end

  // Captured when the access is first seen, shown during the answer cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= '0;
    else if (avs_read && (bus_q == WD_BUS_IDLE))
      rdata_q <= rd_mux;
  end

  assign avs_readdata = rdata_q;
  assign nmi_req = nmi_q;
  assign timeout_system_reset = rst_q;

endmodule : wd_top
`default_nettype wire

// File: inc/wd_pkg.sv
package wd_pkg;

  // Avalon byte address width and data width
  localparam int WD_ADDR_W = 5;
  localparam int WD_DATA_W = 32;

  // Register byte offsets
  localparam logic [WD_ADDR_W-1:0] WD_OFS_COUNT = 5'h00;
  localparam logic [WD_ADDR_W-1:0] WD_OFS_CTRL = 5'h04;
  localparam logic [WD_ADDR_W-1:0] WD_OFS_FRZ_SET = 5'h08;
  localparam logic [WD_ADDR_W-1:0] WD_OFS_FRZ_CLR = 5'h0c;
  localparam logic [WD_ADDR_W-1:0] WD_OFS_STATUS = 5'h10;

  // Counter register fields
  localparam int WD_CNT_W = 9;
  localparam int WD_SIGN_BIT = 8;
  localparam int WD_GUARD_BIT = 9;

  // Control, freeze and status fields
  localparam int WD_SEL_BIT = 0;
  localparam int WD_FRZ_BIT = 0;
  localparam int WD_ST_FROZEN = 0;
  localparam int WD_ST_DBG = 1;
  localparam int WD_ST_SWFRZ = 2;
  localparam int WD_ST_NMI = 3;
  localparam int WD_ST_NEG = 4;
  localparam int WD_ST_REJECT = 5;
  localparam int WD_ST_FIRED = 6;

  // Counter values
  localparam logic [WD_CNT_W-1:0] WD_COUNT_RST = 9'h0ff;
  localparam logic [WD_CNT_W-1:0] WD_COUNT_ZERO = 9'h000;
  localparam logic [WD_CNT_W-1:0] WD_COUNT_ONE = 9'h001;
  localparam logic [WD_CNT_W-1:0] WD_COUNT_NEG_LIMIT = 9'h1f0;

  // Tick timing
  localparam longint WD_CLK_PERIOD_PS = 25000;
  localparam longint WD_TICK_PERIOD_PS = 64'd10240000000;
  localparam int unsigned WD_TICK_CYCLES = int'(WD_TICK_PERIOD_PS / WD_CLK_PERIOD_PS);

  typedef enum logic [0:0] {WD_BUS_IDLE, WD_BUS_ACK} wd_bus_e;

  // Signed compare of a 9-bit counter against a limit
  function automatic logic wd_at_or_below(input logic [WD_CNT_W-1:0] v,
                                          input logic [WD_CNT_W-1:0] lim);
    wd_at_or_below = $signed(v) <= $signed(lim);
  endfunction : wd_at_or_below

endpackage : wd_pkg

// File: inc/wd_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wd_tick_if;
  logic tick;
  logic run;
  modport src (output tick, input run);
  modport snk (input tick, output run);
endinterface : wd_tick_if
`default_nettype wire

// File: verification/wd_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module wd_top_chk
  import wd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = WD_TICK_CYCLES
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WD_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [WD_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [WD_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic debug_core_halted,
  input wire logic nmi_req,
  input wire logic timeout_system_reset
);
  logic acc_wr;
  logic st_rd;
  // Only a guarded, full-lane counter write counts as accepted
  assign acc_wr = avs_write && !avs_waitrequest && avs_address[4:2] == 3'h0 &&
                  !avs_writedata[WD_GUARD_BIT] && avs_byteenable[1:0] == 2'h3;
  assign st_rd = avs_read && !avs_waitrequest && avs_address[4:2] == 3'h4;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_fire_sticky: assert property (timeout_system_reset |=> timeout_system_reset)
    else $error("timeout reset dropped");
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer not after one wait state");
  a_idle_free: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest while idle");
  a_nmi_clear: assert property (acc_wr && !avs_writedata[8] && avs_writedata[7:0] > 8'h01 |=> !nmi_req)
    else $error("nmi kept after reload");
  a_nmi_hold: assert property (nmi_req && !acc_wr |=> nmi_req)
    else $error("nmi dropped without reload");
  a_halt_quiet: assert property ((debug_core_halted && !avs_write)[*3] |=> !$rose(nmi_req) && !$rose(timeout_system_reset))
    else $error("event while halted");
  a_guard_zero: assert property (avs_read && !avs_waitrequest && avs_address[4:2] == 3'h0 |-> avs_readdata[31:9] == 23'h0)
    else $error("counter upper bits not zero");
  a_status_mirror: assert property (st_rd |-> avs_readdata[WD_ST_NMI] == $past(nmi_req) && avs_readdata[WD_ST_FIRED] == $past(timeout_system_reset))
    else $error("status disagrees with outputs");
endmodule : wd_top_chk
bind wd_top wd_top_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.clk(clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .debug_core_halted(debug_core_halted),
  .nmi_req(nmi_req), .timeout_system_reset(timeout_system_reset));
`default_nettype wire

// File: verification/wd_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module wd_top_tb_top
  import wd_pkg::*;
;
  localparam int unsigned TC = 8;
  logic clk, nrst, avs_read, avs_write, avs_waitrequest, debug_core_halted;
  logic nmi_req, timeout_system_reset, w_s, n_s, t_s;
  logic [WD_ADDR_W-1:0] avs_address;
  logic [WD_DATA_W-1:0] avs_writedata, avs_readdata, rd_s, d;
  logic [3:0] avs_byteenable;
  int mismatches, checked, n;
  wd_top #(.TICK_CYCLES(TC)) i_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .debug_core_halted(debug_core_halted),
    .nmi_req(nmi_req), .timeout_system_reset(timeout_system_reset));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Mid-cycle copies avoid racing the design at the rising edge
  always @(negedge clk)
  begin
    w_s = avs_waitrequest;
    rd_s = avs_readdata;
    n_s = nmi_req;
    t_s = timeout_system_reset;
  end
  task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s exp %h got %h", s, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    do @(posedge clk); while (w_s !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (w_s !== 1'b0);
    v = rd_s;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic rc(input logic [4:0] a, input logic [31:0] e, input string s);
    logic [31:0] v;
    rd(a, v);
    chk(s, v, e);
  endtask : rc
  task automatic hold_until(input bit fire);
    n = 0;
    while ((fire ? t_s : n_s) !== 1'b1)
    begin
      @(posedge clk);
      n++;
    end
  endtask : hold_until
  task automatic results();
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
  initial
  begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    debug_core_halted = 1'b1;
    mismatches = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (40) @(posedge clk);
    rc(WD_OFS_COUNT, 32'h0ff, "count");
    rc(WD_OFS_STATUS, 32'h03, "status");
    wr(WD_OFS_COUNT, 32'h3ff);
    rc(WD_OFS_COUNT, 32'h0ff, "guarded");
    rc(WD_OFS_STATUS, 32'h23, "reject");
    wr(WD_OFS_STATUS, 32'h20);
    avs_byteenable <= 4'h1;
    wr(WD_OFS_COUNT, 32'h005);
    avs_byteenable <= 4'hf;
    wr(5'h14, 32'hffffffff);
    rc(5'h14, 32'h0, "unmapped");
    rc(WD_OFS_COUNT, 32'h0ff, "lanes");
    wr(WD_OFS_COUNT, 32'h005);
    debug_core_halted <= 1'b0;
    wr(WD_OFS_FRZ_SET, 32'h1);
    repeat (40) @(posedge clk);
    rc(WD_OFS_STATUS, 32'h05, "swfreeze");
    rc(WD_OFS_COUNT, 32'h005, "frozen");
    wr(WD_OFS_FRZ_CLR, 32'h1);
    hold_until(1'b0);
    chk("nmi time", 32'(n >= 4 * TC && n <= 5 * TC + 4), 32'h1);
    debug_core_halted <= 1'b1;
    rc(WD_OFS_COUNT, 32'h0, "zero");
    rc(WD_OFS_STATUS, 32'h0b, "nmi st");
    debug_core_halted <= 1'b0;
    hold_until(1'b1);
    chk("fire time", 32'(n >= 15 * TC && n <= 16 * TC + 4), 32'h1);
    rc(WD_OFS_COUNT, 32'h1f0, "limit");
    rd(WD_OFS_STATUS, d);
    chk("fired st", d & 32'h58, 32'h58);
    nrst <= 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rc(WD_OFS_COUNT, 32'h0ff, "wd reset");
    chk("fire low", t_s, 32'h0);
    wr(WD_OFS_COUNT, 32'h002);
    hold_until(1'b0);
    wr(WD_OFS_COUNT, 32'h0ff);
    repeat (2) @(posedge clk);
    chk("nmi clr", n_s, 32'h0);
    wr(WD_OFS_CTRL, 32'h1);
    wr(WD_OFS_CTRL, 32'h0);
    rc(WD_OFS_CTRL, 32'h1, "mode");
    wr(WD_OFS_FRZ_SET, 32'h1);
    rd(WD_OFS_STATUS, d);
    chk("no freeze", d & 32'h4, 32'h0);
    wr(WD_OFS_COUNT, 32'h002);
    hold_until(1'b1);
    chk("mode1 nmi", n_s, 32'h0);
    rc(WD_OFS_COUNT, 32'h0, "mode1 end");
    results();
  end
endmodule : wd_top_tb_top
`default_nettype wire
